// file: hdl/ssi_deglitch.sv
`timescale 1ns/1ns
`default_nettype none
module ssi_deglitch
    import ssi_pkg::*;
#(
    parameter logic [DG_W-1:0] ASSERT_CYC = 16'h0001,
    parameter logic [DG_W-1:0] RELEASE_CYC = 16'h0001
) (
    input wire logic clk,
    input wire logic resetn,
    ssi_dg_if.filt dg
);
    logic level_ff;
    logic [DG_W-1:0] cnt_ff;
    logic [DG_W-1:0] nxt_cnt;
    logic nxt_level;
    wire logic differ;
    wire logic [DG_W-1:0] limit;
    wire logic done;

    // The request must stand unbroken for the whole interval; any bounce restarts it
    assign differ = dg.want_high != level_ff;
    assign limit = level_ff ? RELEASE_CYC : ASSERT_CYC;
    assign done = differ && (cnt_ff == limit - 16'h0001);

    always_comb begin
        nxt_level = level_ff;
        nxt_cnt = 16'h0000;
        if (dg.drop_now) begin
            nxt_level = 1'b0;
        end else if (done) begin
            nxt_level = dg.want_high;
        end else if (differ) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level_ff <= 1'b0;
            cnt_ff <= 16'h0000;
        end else begin
            level_ff <= nxt_level;
            cnt_ff <= nxt_cnt;
        end
    end

    assign dg.level = level_ff;
endmodule
`default_nettype wire

// file: hdl/ssi_dg_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ssi_dg_if;
    logic want_high;
    logic drop_now;
    logic level;
    modport ctrl (output want_high, output drop_now, input level);
    modport filt (input want_high, input drop_now, output level);
endinterface
`default_nettype wire

// file: hdl/ssi_pkg.sv
package ssi_pkg;

    // ***********************************************
    // Clock and deglitch timing
    // ***********************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEF_ASSERT_NS = 10000;
    localparam int DEF_RELEASE_NS = 10000;
    localparam int DG_W = 16;

    // ***********************************************
    // Register map
    // ***********************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_FAULT = 8'h08;
    localparam logic [7:0] OFS_EVENT = 8'h0c;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int CTRL_HOLD_BIT = 0;
    localparam int ST_AUX_BIT = 0;
    localparam int ST_GOOD_BIT = 1;
    localparam int ST_INRUSH_BIT = 2;
    localparam int ST_ABOVE_BIT = 3;
    localparam int ST_CLAMP_LSB = 4;
    localparam int FAULT_N = 11;
    localparam int EV_AUX_DROP = 0;
    localparam int EV_GOOD_DROP = 1;
    localparam int EV_GOOD_RISE = 2;
    localparam int EV_N = 3;

    // ***********************************************
    // Clamp strap codes
    // ***********************************************
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_OPEN = 2'h1;
    localparam logic [1:0] STRAP_RES = 2'h2;

    typedef enum logic [1:0] {CLAMP_3V8, CLAMP_5V7, CLAMP_13V8} ssi_clamp_t;
    typedef enum logic [1:0] {AUX_OFF, AUX_INRUSH, AUX_ON} ssi_aux_st_t;

endpackage

// file: hdl/ssi_status_top.sv
// Summary of operation
// - Auxiliary flag stays low after power-up while the pass switch ramps up.
// - Auxiliary flag goes high once the gate reaches full overdrive.
// - Auxiliary flag drops only on undervoltage, lockout, reverse polarity or overvoltage lockout.
// - Load-side faults never drop the auxiliary flag.
// - Supply-good flag stays low after power-up until its conditions hold.
// - Supply-good asserts after inrush done and threshold above rising, after assert deglitch.
// - Supply-good releases on threshold below falling or any fault other than overcurrent and short.
// - Threshold or slow-fault release waits the release deglitch interval.
// - Undervoltage, reverse polarity and overtemperature drop supply-good at once.
// - Overcurrent and short keep supply-good following the threshold.
// - Monitor-pin faults drop supply-good directly as slow faults, not via the threshold, after release deglitch.
// - Strap grounded selects 3.8 V, open 5.7 V, resistor 13.8 V.
`timescale 1ns/1ns
`default_nettype none
module ssi_status_top
    import ssi_pkg::*;
#(
    parameter int GOOD_ASSERT_NS = DEF_ASSERT_NS,
    parameter int GOOD_RELEASE_NS = DEF_RELEASE_NS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic gate_full_overdrive,
    input wire logic input_undervoltage_protect,
    input wire logic undervoltage_lockout,
    input wire logic reverse_polarity,
    input wire logic overvoltage_lockout,
    input wire logic overcurrent,
    input wire logic short_circuit,
    input wire logic breaker_trip,
    input wire logic ilm_open,
    input wire logic ilm_short,
    input wire logic reverse_current,
    input wire logic over_temp,
    input wire logic good_above_rising,
    input wire logic good_below_falling,
    input wire logic [1:0] clamp_level_strap,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic aux_channel_control_flag_o,
    output logic aux_channel_control_flag_oe,
    output logic supply_good_flag_o,
    output logic supply_good_flag_oe,
    output logic [1:0] overvoltage_clamp_sel
);

    // ***********************************************
    // Deglitch lengths
    // ***********************************************
    localparam int ASSERT_RAW = GOOD_ASSERT_NS / CLK_PERIOD_NS;
    localparam int RELEASE_RAW = GOOD_RELEASE_NS / CLK_PERIOD_NS;
    // Never shorter than one cycle
    localparam logic [DG_W-1:0] ASSERT_CYC =
        DG_W'((ASSERT_RAW < 1) ? 1 : ASSERT_RAW);
    localparam logic [DG_W-1:0] RELEASE_CYC =
        DG_W'((RELEASE_RAW < 1) ? 1 : RELEASE_RAW);

    // ***********************************************
    // Helpers
    // ***********************************************
    function automatic ssi_clamp_t strap_decode(
        input logic [1:0] code
    );
        ssi_clamp_t res;
        res = CLAMP_5V7;
        case (code)
            STRAP_GND: begin
                res = CLAMP_3V8;
            end
            STRAP_OPEN: begin
                res = CLAMP_5V7;
            end
            STRAP_RES: begin
                res = CLAMP_13V8;
            end
            default: begin
                // Unreadable strap behaves as open
                res = CLAMP_5V7;
            end
        endcase
        return res;
    endfunction

    function automatic logic addr_hit(
        input logic [7:0] a,
        input logic [7:0] ofs
    );
        return a == ofs;
    endfunction

    // ***********************************************
    // Declarations
    // ***********************************************
    ssi_aux_st_t aux_st_ff;
    ssi_aux_st_t nxt_aux_st;
    ssi_clamp_t clamp_ff;
    logic strap_taken_ff;
    logic thr_high_ff;
    logic nxt_thr_high;
    logic good_prev_ff;
    logic aux_prev_ff;
    logic [31:0] ctrl_ff;
    logic [EV_N-1:0] event_ff;
    logic [EV_N-1:0] nxt_event;
    logic [31:0] rdata_ff;
    logic aux_oe_ff;
    logic good_oe_ff;
    logic pin_low_ff;

    wire logic input_invalid;
    wire logic fast_fault;
    wire logic slow_fault;
    wire logic inrush_done;
    wire logic hold_good;
    wire logic good_level;
    wire logic [FAULT_N-1:0] fault_vec;
    wire logic [31:0] status_word;
    wire logic [31:0] rd_mux;
    wire logic wr_ctrl;
    wire logic wr_event;
    wire logic [EV_N-1:0] ev_set;
    wire logic [EV_N-1:0] ev_clr;

    ssi_dg_if dg ();

    // ***********************************************
    // Input validity
    // ***********************************************
    assign input_invalid = input_undervoltage_protect
        | undervoltage_lockout
        | reverse_polarity
        | overvoltage_lockout;

    // ***********************************************
    // Auxiliary channel state
    // ***********************************************
    // Load-side fault inputs are deliberately absent here
    always_comb begin
        nxt_aux_st = aux_st_ff;
        case (aux_st_ff)
            AUX_OFF: begin
                if (!input_invalid) begin
                    nxt_aux_st = AUX_INRUSH;
                end
            end
            AUX_INRUSH: begin
                if (input_invalid) begin
                    nxt_aux_st = AUX_OFF;
                end else if (gate_full_overdrive) begin
                    nxt_aux_st = AUX_ON;
                end
            end
            AUX_ON: begin
                if (input_invalid) begin
                    nxt_aux_st = AUX_OFF;
                end
            end
            default: begin
                nxt_aux_st = AUX_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aux_st_ff <= AUX_OFF;
        end else begin
            aux_st_ff <= nxt_aux_st;
        end
    end

    assign inrush_done = aux_st_ff == AUX_ON;

    // ***********************************************
    // Threshold comparator with hysteresis
    // ***********************************************
    // Between the two thresholds the last decision stands
    always_comb begin
        nxt_thr_high = thr_high_ff;
        if (good_below_falling) begin
            nxt_thr_high = 1'b0;
        end else if (good_above_rising) begin
            nxt_thr_high = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            thr_high_ff <= 1'b0;
        end else begin
            thr_high_ff <= nxt_thr_high;
        end
    end

    // ***********************************************
    // Supply-good decision
    // ***********************************************
    assign fast_fault = input_undervoltage_protect
        | undervoltage_lockout
        | reverse_polarity
        | over_temp;
    // Overcurrent and short are left out so the flag keeps tracking the threshold
    assign slow_fault = overvoltage_lockout
        | breaker_trip
        | ilm_open
        | ilm_short
        | reverse_current;
    assign hold_good = ctrl_ff[CTRL_HOLD_BIT];

    assign dg.want_high = inrush_done
        & thr_high_ff
        & ~slow_fault
        & ~fast_fault;
    assign dg.drop_now = fast_fault | hold_good;

    ssi_deglitch #(
        .ASSERT_CYC(ASSERT_CYC),
        .RELEASE_CYC(RELEASE_CYC)
    ) u_good_dg (
        .clk(clk),
        .resetn(resetn),
        .dg(dg)
    );

    assign good_level = dg.level;

    // ***********************************************
    // Clamp strap
    // ***********************************************
    // Strap is read once, on the first edge after reset release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strap_taken_ff <= 1'b0;
            clamp_ff <= CLAMP_5V7;
        end else if (!strap_taken_ff) begin
            strap_taken_ff <= 1'b1;
            clamp_ff <= strap_decode(clamp_level_strap);
        end
    end

    // ***********************************************
    // Open-drain pins
    // ***********************************************
    // Pins only sink; the pull-up lives outside, so high means released
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aux_oe_ff <= 1'b1;
            good_oe_ff <= 1'b1;
            pin_low_ff <= 1'b0;
        end else begin
            aux_oe_ff <= ~inrush_done;
            good_oe_ff <= ~good_level;
            pin_low_ff <= 1'b0;
        end
    end

    // ***********************************************
    // Register access
    // ***********************************************
    assign wr_ctrl = reg_wr & addr_hit(reg_addr, OFS_CTRL);
    assign wr_event = reg_wr & addr_hit(reg_addr, OFS_EVENT);

    assign fault_vec = {
        over_temp,
        reverse_current,
        ilm_short,
        ilm_open,
        breaker_trip,
        short_circuit,
        overcurrent,
        overvoltage_lockout,
        reverse_polarity,
        undervoltage_lockout,
        input_undervoltage_protect
    };

    assign status_word = {
        26'h0,
        clamp_ff,
        thr_high_ff,
        inrush_done,
        good_level,
        inrush_done
    };

    // Edge events; a set in the clearing cycle wins
    assign ev_set[EV_AUX_DROP] = aux_prev_ff & ~inrush_done;
    assign ev_set[EV_GOOD_DROP] = good_prev_ff & ~good_level;
    assign ev_set[EV_GOOD_RISE] = ~good_prev_ff & good_level;
    assign ev_clr = wr_event ? reg_wdata[EV_N-1:0] : '0;
    assign nxt_event = (event_ff & ~ev_clr) | ev_set;

    assign rd_mux = addr_hit(reg_addr, OFS_CTRL) ? ctrl_ff
        : addr_hit(reg_addr, OFS_STATUS) ? status_word
        : addr_hit(reg_addr, OFS_FAULT) ? {21'h0, fault_vec}
        : addr_hit(reg_addr, OFS_EVENT) ? {29'h0, event_ff}
        : 32'h0000_0000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= {31'h0, reg_wdata[CTRL_HOLD_BIT]};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            event_ff <= '0;
            aux_prev_ff <= 1'b0;
            good_prev_ff <= 1'b0;
        end else begin
            event_ff <= nxt_event;
            aux_prev_ff <= inrush_done;
            good_prev_ff <= good_level;
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (reg_rd) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    // ***********************************************
    // Outputs
    // ***********************************************
    assign reg_rdata = rdata_ff;
    assign aux_channel_control_flag_o = pin_low_ff;
    assign aux_channel_control_flag_oe = aux_oe_ff;
    assign supply_good_flag_o = pin_low_ff;
    assign supply_good_flag_oe = good_oe_ff;
    assign overvoltage_clamp_sel = clamp_ff;

endmodule
`default_nettype wire

// file: verif/ssi_pullup_model.sv
`timescale 1ns/1ns
`default_nettype none
module ssi_pullup_model (
    input wire logic aux_o,
    input wire logic aux_oe,
    input wire logic good_o,
    input wire logic good_oe,
    output logic aux_level,
    output logic good_level
);
    // The device only sinks; the far side's resistor lifts a released line
    assign aux_level = aux_oe ? aux_o : 1'b1;
    assign good_level = good_oe ? good_o : 1'b1;
endmodule
`default_nettype wire

// file: verif/ssi_status_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module ssi_status_asserts
    import ssi_pkg::*;
#(
    parameter int GOOD_ASSERT_NS = DEF_ASSERT_NS,
    parameter int GOOD_RELEASE_NS = DEF_RELEASE_NS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic gate_full_overdrive,
    input wire logic input_undervoltage_protect,
    input wire logic undervoltage_lockout,
    input wire logic reverse_polarity,
    input wire logic overvoltage_lockout,
    input wire logic breaker_trip,
    input wire logic ilm_open,
    input wire logic ilm_short,
    input wire logic reverse_current,
    input wire logic over_temp,
    input wire logic good_below_falling,
    input wire logic [1:0] clamp_level_strap,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic aux_channel_control_flag_o,
    input wire logic aux_channel_control_flag_oe,
    input wire logic supply_good_flag_o,
    input wire logic supply_good_flag_oe,
    input wire logic [1:0] overvoltage_clamp_sel
);
    localparam int A_CYC = GOOD_ASSERT_NS / CLK_PERIOD_NS;
    localparam int R_CYC = GOOD_RELEASE_NS / CLK_PERIOD_NS;
    logic hold_ff;
    logic [15:0] up_ff;
    logic [15:0] dn_ff;
    wire logic bad_in = input_undervoltage_protect | undervoltage_lockout | reverse_polarity | overvoltage_lockout;
    wire logic fast = input_undervoltage_protect | undervoltage_lockout | reverse_polarity | over_temp;
    // A restarted inrush keeps the good flag low just like a slow fault does
    wire logic slow = good_below_falling | overvoltage_lockout | breaker_trip | ilm_open | ilm_short
        | reverse_current | aux_channel_control_flag_oe;
    wire logic quick = fast | hold_ff;
    wire logic nxt_hold = (reg_wr && reg_addr == OFS_CTRL) ? reg_wdata[CTRL_HOLD_BIT] : hold_ff;
    // Counters saturate so a long steady state never wraps into a false pass
    wire logic [15:0] nxt_up = (quick | slow) ? 16'h0000 : (up_ff == 16'hffff ? up_ff : up_ff + 16'h0001);
    wire logic [15:0] nxt_dn = !slow ? 16'h0000 : (dn_ff == 16'hffff ? dn_ff : dn_ff + 16'h0001);
    wire logic [1:0] clamp_exp = (clamp_level_strap == STRAP_GND) ? CLAMP_3V8 :
        (clamp_level_strap == STRAP_RES) ? CLAMP_13V8 : CLAMP_5V7;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold_ff <= 1'b0;
            up_ff <= 16'h0000;
            dn_ff <= 16'h0000;
        end else begin
            hold_ff <= nxt_hold;
            up_ff <= nxt_up;
            dn_ff <= nxt_dn;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_aux_low: assert property (
        $fell(aux_channel_control_flag_oe) |-> $past(gate_full_overdrive) || $past(gate_full_overdrive, 2))
        else $error("aux flag released without full overdrive");
    a_aux_rise: assert property (
        (gate_full_overdrive && !bad_in)[*5] |-> !aux_channel_control_flag_oe)
        else $error("aux flag not released after inrush");
    a_aux_drop: assert property (
        bad_in |-> ##2 aux_channel_control_flag_oe)
        else $error("aux flag not pulled low on invalid input");
    a_aux_keep: assert property (
        $rose(aux_channel_control_flag_oe) |-> $past(bad_in) || $past(bad_in, 2))
        else $error("aux flag pulled low without invalid input");
    a_sink_only: assert property (
        !aux_channel_control_flag_o && !supply_good_flag_o)
        else $error("open drain output driven high");
    a_good_wait: assert property (
        $fell(supply_good_flag_oe) |-> up_ff >= A_CYC)
        else $error("supply good released before assert interval");
    a_good_rel: assert property (
        $rose(supply_good_flag_oe) |-> $past(quick) || $past(quick, 2) || $past(quick, 3) || dn_ff >= R_CYC)
        else $error("supply good pulled low without cause");
    a_good_fast: assert property (
        fast |-> ##2 supply_good_flag_oe)
        else $error("supply good not dropped at once");
    a_good_slow: assert property (
        dn_ff >= R_CYC + 4 |-> supply_good_flag_oe)
        else $error("supply good not dropped after release interval");
    a_clamp_map: assert property (
        $rose(resetn) |=> overvoltage_clamp_sel == clamp_exp)
        else $error("clamp select does not match strap");
endmodule

bind ssi_status_top ssi_status_asserts #(
    .GOOD_ASSERT_NS(GOOD_ASSERT_NS),
    .GOOD_RELEASE_NS(GOOD_RELEASE_NS)
) i_ssi_status_asserts (
    .clk(clk), .resetn(resetn), .gate_full_overdrive(gate_full_overdrive),
    .input_undervoltage_protect(input_undervoltage_protect), .undervoltage_lockout(undervoltage_lockout),
    .reverse_polarity(reverse_polarity), .overvoltage_lockout(overvoltage_lockout),
    .breaker_trip(breaker_trip), .ilm_open(ilm_open), .ilm_short(ilm_short),
    .reverse_current(reverse_current), .over_temp(over_temp), .good_below_falling(good_below_falling),
    .clamp_level_strap(clamp_level_strap), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .aux_channel_control_flag_o(aux_channel_control_flag_o),
    .aux_channel_control_flag_oe(aux_channel_control_flag_oe),
    .supply_good_flag_o(supply_good_flag_o), .supply_good_flag_oe(supply_good_flag_oe),
    .overvoltage_clamp_sel(overvoltage_clamp_sel)
);
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
    import ssi_pkg::*;
;
    localparam int A_CYC = 50 / CLK_PERIOD_NS;
    logic clk, resetn, od, above, wr, rd, aux_o, aux_oe, good_o, good_oe, aux_lv, good_lv;
    logic [11:0] flt;
    logic [1:0] strap, csel;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    int n, checks, mismatches;
    // Row packing: fault vector in [13:2], then expected aux and good levels
    logic [13:0] rows [13] = '{14'h0003, 14'h0004, 14'h0008, 14'h0010, 14'h0020, 14'h0043, 14'h0083,
        14'h0102, 14'h0202, 14'h0402, 14'h0802, 14'h1002, 14'h2002};
    logic [1:0] clamp_tab [4] = '{2'h0, 2'h1, 2'h2, 2'h1};

    ssi_status_top #(.GOOD_ASSERT_NS(50), .GOOD_RELEASE_NS(50)) i_ssi_status_top (
        .clk(clk), .resetn(resetn), .gate_full_overdrive(od), .input_undervoltage_protect(flt[0]),
        .undervoltage_lockout(flt[1]), .reverse_polarity(flt[2]), .overvoltage_lockout(flt[3]),
        .overcurrent(flt[4]), .short_circuit(flt[5]), .breaker_trip(flt[6]), .ilm_open(flt[7]),
        .ilm_short(flt[8]), .reverse_current(flt[9]), .over_temp(flt[10]), .good_above_rising(above),
        .good_below_falling(flt[11]), .clamp_level_strap(strap), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .aux_channel_control_flag_o(aux_o),
        .aux_channel_control_flag_oe(aux_oe), .supply_good_flag_o(good_o), .supply_good_flag_oe(good_oe),
        .overvoltage_clamp_sel(csel)
    );
    ssi_pullup_model i_ssi_pullup_model (
        .aux_o(aux_o), .aux_oe(aux_oe), .good_o(good_o), .good_oe(good_oe),
        .aux_level(aux_lv), .good_level(good_lv)
    );

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    // ****************************************
    // Helpers
    // ****************************************
    task automatic results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_good(output int cnt);
        cnt = 0;
        while (good_lv !== 1'b1 && cnt < 60) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        if (good_lv !== 1'b1) begin
            mismatches++;
            $display("FAIL timeout on supply good");
            results();
        end
    endtask

    task automatic apply(input logic [11:0] f, input int cyc);
        @(posedge clk);
        flt <= f;
        repeat (cyc) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        od = 1'b0;
        above = 1'b1;
        flt = 12'h000;
        strap = STRAP_OPEN;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        checks = 0;
        mismatches = 0;
        repeat (10) @(posedge clk);
        #1;
        check("aux in reset", aux_lv, 1'b0);
        check("good in reset", good_lv, 1'b0);
        apply(12'h000, 0);
        resetn <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        check("aux in inrush", aux_lv, 1'b0);
        check("good in inrush", good_lv, 1'b0);
        @(posedge clk);
        od <= 1'b1;
        wait_good(n);
        check("good assert delay", n >= A_CYC, 1'b1);
        check("aux after inrush", aux_lv, 1'b1);
        foreach (rows[i]) begin
            apply(rows[i][13:2], 12);
            check("aux per event", aux_lv, rows[i][1]);
            check("good per event", good_lv, rows[i][0]);
            apply(12'h000, 0);
            wait_good(n);
        end
        // A dip shorter than the release interval must be filtered
        apply(12'h800, 2);
        apply(12'h000, 10);
        check("good after dip", good_lv, 1'b1);
        apply(12'h400, 3);
        check("good on overtemp", good_lv, 1'b0);
        apply(12'h000, 0);
        wait_good(n);
        apply(12'h008, 3);
        check("aux on lockout", aux_lv, 1'b0);
        check("good before release", good_lv, 1'b1);
        apply(12'h000, 0);
        wait_good(n);
        // Between the thresholds the flag must not come back
        @(posedge clk);
        above <= 1'b0;
        apply(12'h800, 12);
        apply(12'h000, 12);
        check("good between thresholds", good_lv, 1'b0);
        @(posedge clk);
        above <= 1'b1;
        wait_good(n);
        rd_reg(OFS_STATUS, d);
        check("status", d, 32'h0000_001f);
        rd_reg(8'h10, d);
        check("unmapped read", d, 32'h0);
        wr_reg(OFS_CTRL, 32'h1);
        apply(12'h000, 3);
        check("good on hold", good_lv, 1'b0);
        rd_reg(OFS_CTRL, d);
        check("ctrl readback", d, 32'h1);
        @(posedge clk);
        #1;
        check("read data one cycle", rdata, 32'h0);
        wr_reg(OFS_CTRL, 32'h0);
        wait_good(n);
        apply(12'h010, 0);
        rd_reg(OFS_FAULT, d);
        check("fault word", d, 32'h0000_0010);
        check("good on overcurrent", good_lv, 1'b1);
        rd_reg(OFS_EVENT, d);
        check("events", d, 32'h0000_0007);
        wr_reg(OFS_EVENT, 32'h0000_0007);
        rd_reg(OFS_EVENT, d);
        check("events cleared", d, 32'h0);
        apply(12'h000, 0);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            resetn <= 1'b0;
            strap <= 2'(s);
            repeat (2) @(posedge clk);
            resetn <= 1'b1;
            repeat (3) @(posedge clk);
            #1;
            check("clamp select", csel, clamp_tab[s]);
        end
        results();
    end
endmodule
`default_nettype wire
